//--- bench/pdmcc_checker.sv
// port checker for pdmcc_top
// assumes one aclk domain, bound to every pdmcc_top
`timescale 1ns/1ps
module pdmcc_checker
	import pdmcc_pkg::*;
(
	input wire logic        aclk,
	input wire logic        aresetn,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        pll_clk_en,
	input wire logic        osc_clk_en,
	input wire logic        mclk_pin_in,
	input wire logic        mclk_pin_out,
	input wire logic        mclk_pin_oe,
	input wire logic        clock_out_branch,
	input wire logic        master_clock_branch,
	input wire logic        pll_osc_en,
	input wire logic        tx_ref_clk
);
	// =====================================================
	// properties
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_c1; $changed(clock_out_branch) |-> $past(pll_clk_en); endproperty
	a_c1: assert property (p_c1) else $error("clock out branch moved off enable");
	property p_c2; $changed(master_clock_branch) |-> $past(pll_clk_en); endproperty
	a_c2: assert property (p_c2) else $error("master branch moved off enable");
	property p_rst; $rose(aresetn) |-> !clock_out_branch && !master_clock_branch && !mclk_pin_oe;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
	property p_txs;
		!$past(mclk_pin_oe) && $past(aresetn) |-> tx_ref_clk == $past(mclk_pin_in);
	endproperty
	a_txs: assert property (p_txs) else $error("tx reference not pin input");
	property p_txm;
		$past(mclk_pin_oe) && $past(aresetn) |-> tx_ref_clk == $past(mclk_pin_out);
	endproperty
	a_txm: assert property (p_txm) else $error("tx reference not driven clock");
	property p_osc; pll_osc_en |-> osc_clk_en; endproperty
	a_osc: assert property (p_osc) else $error("pll input enable without oscillator");
	property p_bh; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bh: assert property (p_bh) else $error("write response dropped");
	property p_rl; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rl: assert property (p_rl) else $error("read answer late");
	property p_rh; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rh: assert property (p_rh) else $error("read data dropped");
	c_oe: cover property (mclk_pin_oe);
	c_c1: cover property ($rose(clock_out_branch));
	c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // pdmcc_checker
bind pdmcc_top pdmcc_checker pdmcc_checker_inst (.*);

//--- bench/pdmcc_mclk_partner.sv
// audio device on the master clock pin
// assumes pin level resolved here from the design enable
`timescale 1ns/1ps
module pdmcc_mclk_partner (
	input  wire logic aclk,
	input  wire logic oe,
	input  wire logic drv,
	output logic      pin
);
	logic       ext_r = 1'b0;
	logic [2:0] cnt_r = 3'h0;
	// =====================================================
	// slave side clock, toggles every five cycles
	always_ff @(posedge aclk) begin
		cnt_r <= (cnt_r == 3'h4) ? 3'h0 : cnt_r + 3'h1;
		if (cnt_r == 3'h4) ext_r <= ~ext_r;
	end
	assign pin = oe ? drv : ext_r;
endmodule // pdmcc_mclk_partner

//--- bench/test_pll_divider_master_clock_control.sv
// testbench for pdmcc_top: registers, ratio, dividers, pin, prescale
// assumes 25 MHz aclk and the pin partner model
`timescale 1ns/1ps
module test_pll_divider_master_clock_control;
	import pdmcc_pkg::*;
	logic              aclk = 1'b0, aresetn = 1'b0, pll_clk_en = 1'b1, osc_clk_en = 1'b0;
	logic              rx_active = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic              s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rd;
	logic [3:0]        s_axi_wstrb = 4'hf;
	logic [1:0]        rx_post_divider_mode = 2'h0, s_axi_bresp, s_axi_rresp, rs, e;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic              mclk_pin_in, mclk_pin_out, mclk_pin_oe, clock_out_branch;
	logic              master_clock_branch, pll_osc_en, tx_ref_clk;
	logic [25:0]       pll_ratio;
	logic [7:0]        d;
	int                errors = 0, n_tests = 0, seed = 59, oc = 0, no, np, q;
	int                pr [3];
	int                bse [4] = '{2, 4, 8, 12};
	logic [7:0]        ix [7] = '{IDX_FRAC_LO, IDX_FRAC_MID, IDX_FRAC_HI, IDX_INT_PRE,
		IDX_POST_DIV, IDX_CLK_SRC, IDX_AIF_RX};
	logic [7:0]        mk [7] = '{8'hff, 8'hff, 8'h3f, 8'h1f, 8'h3f, 8'h98, 8'hff};
	logic [31:0]       rv [7] = '{RST_FRAC_LO, RST_FRAC_MID, RST_FRAC_HI, RST_INT,
		RST_POST_DIV, RST_CLK_SRC, RST_AIF_RX};
	localparam logic [25:0] RATIO0 = {RST_INT, RST_FRAC_HI, RST_FRAC_MID, RST_FRAC_LO};
	pdmcc_top pdmcc_top_inst (.*);
	pdmcc_mclk_partner pdmcc_mclk_partner_inst (.aclk(aclk), .oe(mclk_pin_oe),
		.drv(mclk_pin_out), .pin(mclk_pin_in));
	// =====================================================
	// clock, oscillator pulses, watchdog
	initial forever #20 aclk = ~aclk;
	always @(posedge aclk) begin
		oc <= oc + 1;
		osc_clk_en <= (oc % 4) == 0;
	end
	initial begin
		#1600000;
		errors++;
		stop_test;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'b00};
		s_axi_wdata <= {24'h0, v};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		rs = s_axi_bresp;
	endtask
	task automatic rdr(input logic [7:0] i);
		@(posedge aclk);
		s_axi_araddr <= {i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		rd = s_axi_rdata;
		rs = s_axi_rresp;
	endtask
	task automatic per;
		logic [2:0] v, o;
		int         n [3];
		o = 3'h7;
		n = '{0, 0, 0};
		pr = '{0, 0, 0};
		repeat (600) begin
			@(posedge aclk);
			v = {mclk_pin_out, master_clock_branch, clock_out_branch};
			for (int j = 0; j < 3; j++) begin
				if (v[j] && !o[j]) n[j]++;
				if (n[j] == 3) pr[j]++;
			end
			o = v;
		end
	endtask
	// =====================================================
	// main sequence
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		check(pll_ratio, RATIO0);
		for (int k = 0; k < 7; k++) begin
			rdr(ix[k]);
			check(rd, rv[k]);
			d = $random(seed);
			wr(ix[k], d);
			rv[k] = {24'h0, d & mk[k]};
			rdr(ix[k]);
			check(rd, rv[k]);
		end
		wr(8'h10, 8'hff);
		check(rs, RESP_SLVERR);
		rdr(8'h10);
		check({rs, rd[29:0]}, {RESP_SLVERR, 30'h0});
		check(pll_ratio, {rv[3][3:0], rv[2][5:0], rv[1][7:0], rv[0][7:0]}
			& {4'hf, {22{rv[4][2]}}});
		wr(IDX_POST_DIV, rv[4][7:0] ^ 8'h04);
		repeat (2) @(posedge aclk);
		check(pll_ratio, {rv[3][3:0], rv[2][5:0], rv[1][7:0], rv[0][7:0]}
			& {4'hf, {22{~rv[4][2]}}});
		$display("registers and ratio done");
		for (int k = 0; k < 20; k++) begin
			e = k[4] ? k[1:0] : k[3:2];
			rx_active <= k[4];
			rx_post_divider_mode <= e;
			wr(IDX_POST_DIV, {2'b00, k[1:0], k[0], 1'b1, k[4] ? ~e : e});
			per;
			check(pr[0], (k[1:0] == 0) ? ((e == 0) ? 2 : bse[e] / 2)
				: bse[e] << (k[1:0] - 1));
			check(pr[1], bse[e] << k[0]);
			rdr(IDX_POST_DIV);
			check(rd[1:0], e);
		end
		rx_active <= 1'b0;
		$display("dividers done");
		wr(IDX_POST_DIV, 8'h1e);
		wr(IDX_CLK_SRC, 8'h18);
		wr(IDX_AIF_RX, 8'h40);
		per;
		check(mclk_pin_oe, 1'b1);
		check(pr[2], 16);
		wr(IDX_CLK_SRC, 8'h98);
		per;
		q = pr[2];
		check(q, 8);
		wr(IDX_POST_DIV, 8'h16);
		per;
		check(pr[2], q);
		wr(IDX_AIF_RX, 8'h00);
		repeat (4) @(posedge aclk);
		check(mclk_pin_oe, 1'b0);
		$display("master clock pin done");
		for (int k = 0; k < 2; k++) begin
			wr(IDX_INT_PRE, {3'h0, k[0], 4'h8});
			no = 0;
			np = 0;
			repeat (400) begin
				@(posedge aclk);
				no += osc_clk_en;
				np += pll_osc_en;
			end
			check(np, no >> k);
		end
		wr(IDX_FRAC_LO, 8'hba);
		wr(IDX_FRAC_MID, 8'h49);
		wr(IDX_FRAC_HI, 8'h0c);
		repeat (2) @(posedge aclk);
		check(pll_ratio, {4'h8, 22'h0c49ba});
		$display("prescale done");
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		rdr(IDX_POST_DIV);
		check(rd, {24'h0, RST_POST_DIV});
		check(pll_ratio, RATIO0);
		$display("second reset done");
		stop_test;
	end
endmodule // test_pll_divider_master_clock_control

//--- hdl/pdmcc_pkg.sv
// package for the post-pll divider and master clock control block
// assumes one 25 MHz clock and an axi4-lite register slave
package pdmcc_pkg;
	// =====================================================
	// register word indices and address width (printed offsets not all word aligned)
	localparam logic [7:0]  IDX_FRAC_LO     = 8'h03;
	localparam logic [7:0]  IDX_FRAC_MID    = 8'h04;
	localparam logic [7:0]  IDX_FRAC_HI     = 8'h05;
	localparam logic [7:0]  IDX_INT_PRE     = 8'h06;
	localparam logic [7:0]  IDX_POST_DIV    = 8'h07;
	localparam logic [7:0]  IDX_CLK_SRC     = 8'h08;
	localparam logic [7:0]  IDX_AIF_RX      = 8'h1c;
	localparam logic [7:0]  IDX_MODE_CTRL   = 8'h30;
	localparam logic [7:0]  IDX_STATUS      = 8'h31;
	localparam int          ADDR_W          = 10;
	// =====================================================
	// field positions
	localparam int          POS_FRACTIONAL_ENABLE      = 2;
	localparam int          POS_MCLK_DIVIDE_SELECT     = 3;
	localparam int          POS_MS          = 6;
	localparam int          POS_MCLK_SOURCE_SELECT     = 7;
	localparam int          POS_PRESCALE    = 4;
	// =====================================================
	// reset values, response codes, divide limit
	localparam logic [7:0]  RST_FRAC_LO     = 8'h21;
	localparam logic [7:0]  RST_FRAC_MID    = 8'hfd;
	localparam logic [5:0]  RST_FRAC_HI     = 6'h36;
	localparam logic [3:0]  RST_INT         = 4'h7;
	localparam logic [7:0]  RST_POST_DIV    = 8'h16;
	localparam logic [7:0]  RST_CLK_SRC     = 8'h18;
	localparam logic [7:0]  RST_AIF_RX      = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;
	localparam logic [5:0]  DIV_MAX         = 6'h30;
endpackage

//--- hdl/pdmcc_top.sv
// pll divider and master clock control: registers, ratio word, post dividers
// assumes pll output and oscillator sampled as clock enables on aclk
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
// Overview of operation
// - fractional_enable 0: ratio uses integer part only, fraction ignored.
// - fractional_enable 1 (reset): ratio is integer plus fraction.
// - master select bit 6: 0 pin input, 1 pin drives chosen clock.
// - source select bit 7: 0 master branch, 1 oscillator clock.
// - oscillator source gives half the oscillator frequency (toggles per enable); divider select ignored.
// - user mode clock out divide from mode and select table.
// - user mode master divide from bit 3 and mode table.
// - receive mode clock out is 512,256,128,64 fs.
// - receive mode master branch is 256 or 128 fs.
// - pin as input: transmitter reference follows the pin clock.
// - fraction is 22 bits over three registers; integer is 4 bits.
// - halving select feeds oscillator or oscillator divided by two.
// - receiver drives post divider mode while receive mode active.
module pdmcc_top
	import pdmcc_pkg::*;
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              pll_clk_en,
	input  wire logic              osc_clk_en,
	input  wire logic              rx_active,
	input  wire logic [1:0]        rx_post_divider_mode,
	input  wire logic              mclk_pin_in,
	output logic                   mclk_pin_out,
	output logic                   mclk_pin_oe,
	output logic                   clock_out_branch,
	output logic                   master_clock_branch,
	output logic                   pll_osc_en,
	output logic [25:0]            pll_ratio,
	output logic                   tx_ref_clk
);
	// =====================================================
	// state
	typedef struct packed {
		logic              aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic              w_got;
		logic [31:0]       w_data;
		logic [3:0]        w_strb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [31:0]       rdata;
		logic [21:0]       frac;
		logic [3:0]        int_part;
		logic              halve;
		logic [7:0]        post_div;
		logic [7:0]        clk_src;
		logic [7:0]        aif_rx;
		logic              halve_tog;
		logic [5:0]        c1_cnt;
		logic [5:0]        c1_half;
		logic              c1_lvl;
		logic [5:0]        c2_cnt;
		logic [5:0]        c2_half;
		logic              c2_lvl;
		logic              osc_lvl;
		logic              mclk_out;
		logic              tx_ref;
	} pdmcc_state_t;

	pdmcc_state_t st_r;
	pdmcc_state_t st_nxt;

	logic [1:0] eff_mode;
	logic [1:0] clkout_sel;
	logic       mclk_sel;
	logic [5:0] c1_div;
	logic [5:0] c2_div;

	// =====================================================
	// divide tables; receive rates map onto the same table under receiver mode
	function automatic logic [5:0] c1_lookup(input logic [1:0] m, input logic [1:0] s);
		logic [5:0] base;
		base = (m == 2'b11) ? 6'h06 : (m == 2'b10) ? 6'h04 : 6'h02;
		if (m == 2'b00 && s == 2'b00) begin
			c1_lookup = 6'h02;
		end else if (m == 2'b00) begin
			c1_lookup = 6'(base << (s - 2'b01));
		end else begin
			c1_lookup = 6'(base << s);
		end
	endfunction

	function automatic logic [5:0] c2_lookup(input logic [1:0] m, input logic s);
		logic [5:0] base;
		base = (m == 2'b11) ? 6'h0c : (m == 2'b10) ? 6'h08 :
			(m == 2'b01) ? 6'h04 : 6'h02;
		c2_lookup = s ? 6'(base << 1) : base;
	endfunction

	always_comb begin
		eff_mode   = rx_active ? rx_post_divider_mode : st_r.post_div[1:0];
		clkout_sel = st_r.post_div[5:4];
		mclk_sel   = st_r.post_div[POS_MCLK_DIVIDE_SELECT];
		c1_div     = c1_lookup(eff_mode, clkout_sel);
		c2_div     = c2_lookup(eff_mode, mclk_sel);
	end

	// =====================================================
	// next state
	always_comb begin
		logic          wr_go;
		logic [7:0]    widx;
		logic [7:0]    ridx;
		logic [7:0]    wb;
		wr_go  = 1'b0;
		widx   = 8'h00;
		ridx   = 8'h00;
		wb     = 8'h00;
		st_nxt = st_r;
		if (s_axi_awvalid && !st_r.aw_got) begin
			st_nxt.aw_got  = 1'b1;
			st_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !st_r.w_got) begin
			st_nxt.w_got  = 1'b1;
			st_nxt.w_data = s_axi_wdata;
			st_nxt.w_strb = s_axi_wstrb;
		end
		if (st_r.bvalid && s_axi_bready) begin
			st_nxt.bvalid = 1'b0;
		end
		if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
			wr_go         = 1'b1;
			widx          = 8'(st_r.aw_addr[ADDR_W-1:2]);
			wb            = st_r.w_data[7:0];
			st_nxt.aw_got = 1'b0;
			st_nxt.w_got  = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp  = RESP_OKAY;
		end
		if (wr_go && st_r.w_strb[0]) begin
			if (widx == IDX_FRAC_LO) begin
				st_nxt.frac[7:0] = wb;
			end else if (widx == IDX_FRAC_MID) begin
				st_nxt.frac[15:8] = wb;
			end else if (widx == IDX_FRAC_HI) begin
				st_nxt.frac[21:16] = wb[5:0];
			end else if (widx == IDX_INT_PRE) begin
				st_nxt.int_part = wb[3:0];
				st_nxt.halve    = wb[POS_PRESCALE];
			end else if (widx == IDX_POST_DIV) begin
				st_nxt.post_div = {2'b00, wb[5:0]};
			end else if (widx == IDX_CLK_SRC) begin
				st_nxt.clk_src = {wb[7], 2'b00, wb[4:3], 3'b000};
			end else if (widx == IDX_AIF_RX) begin
				st_nxt.aif_rx = wb;
			end else if (widx == IDX_MODE_CTRL || widx == IDX_STATUS) begin
				st_nxt.bresp = RESP_OKAY;
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end else if (wr_go && !(widx == IDX_FRAC_LO || widx == IDX_FRAC_MID
			|| widx == IDX_FRAC_HI || widx == IDX_INT_PRE || widx == IDX_POST_DIV
			|| widx == IDX_CLK_SRC || widx == IDX_AIF_RX || widx == IDX_MODE_CTRL
			|| widx == IDX_STATUS)) begin
			st_nxt.bresp = RESP_SLVERR;
		end
		if (st_r.rvalid && s_axi_rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (s_axi_arvalid && !st_r.rvalid) begin
			ridx          = 8'(s_axi_araddr[ADDR_W-1:2]);
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp  = RESP_OKAY;
			st_nxt.rdata  = 32'h0000_0000;
			if (ridx == IDX_FRAC_LO) begin
				st_nxt.rdata[7:0] = st_r.frac[7:0];
			end else if (ridx == IDX_FRAC_MID) begin
				st_nxt.rdata[7:0] = st_r.frac[15:8];
			end else if (ridx == IDX_FRAC_HI) begin
				st_nxt.rdata[5:0] = st_r.frac[21:16];
			end else if (ridx == IDX_INT_PRE) begin
				st_nxt.rdata[4:0] = {st_r.halve, st_r.int_part};
			end else if (ridx == IDX_POST_DIV) begin
				st_nxt.rdata[7:0] = {st_r.post_div[7:2], eff_mode};
			end else if (ridx == IDX_CLK_SRC) begin
				st_nxt.rdata[7:0] = st_r.clk_src;
			end else if (ridx == IDX_AIF_RX) begin
				st_nxt.rdata[7:0] = st_r.aif_rx;
			end else if (ridx == IDX_MODE_CTRL) begin
				st_nxt.rdata[1:0] = {rx_active, st_r.halve};
			end else if (ridx == IDX_STATUS) begin
				st_nxt.rdata[7:0] = {st_r.tx_ref, st_r.mclk_out, mclk_pin_oe,
					st_r.c2_lvl, st_r.c1_lvl, eff_mode, st_r.post_div[POS_FRACTIONAL_ENABLE]};
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
		end
		// prescaler toggles on each oscillator enable
		if (osc_clk_en) begin
			st_nxt.halve_tog = ~st_r.halve_tog;
			st_nxt.osc_lvl   = ~st_r.osc_lvl;
		end
		// dividers: half period latched only at a full period end, no runts
		if (pll_clk_en) begin
			if (st_r.c1_cnt + 6'h01 >= st_r.c1_half) begin
				st_nxt.c1_cnt = 6'h00;
				st_nxt.c1_lvl = ~st_r.c1_lvl;
				if (st_r.c1_lvl) begin
					st_nxt.c1_half = 6'(c1_div >> 1);
				end
			end else begin
				st_nxt.c1_cnt = st_r.c1_cnt + 6'h01;
			end
			if (st_r.c2_cnt + 6'h01 >= st_r.c2_half) begin
				st_nxt.c2_cnt = 6'h00;
				st_nxt.c2_lvl = ~st_r.c2_lvl;
				if (st_r.c2_lvl) begin
					st_nxt.c2_half = 6'(c2_div >> 1);
				end
			end else begin
				st_nxt.c2_cnt = st_r.c2_cnt + 6'h01;
			end
		end
		// pin mux; oscillator source bypasses divider select
		st_nxt.mclk_out = st_r.clk_src[POS_MCLK_SOURCE_SELECT] ? st_r.osc_lvl : st_r.c2_lvl;
		st_nxt.tx_ref   = st_r.aif_rx[POS_MS] ? st_r.mclk_out : mclk_pin_in;
	end

	// =====================================================
	// registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r           <= '0;
			st_r.frac      <= {RST_FRAC_HI, RST_FRAC_MID, RST_FRAC_LO};
			st_r.int_part  <= RST_INT;
			st_r.post_div  <= RST_POST_DIV;
			st_r.clk_src   <= RST_CLK_SRC;
			st_r.aif_rx    <= RST_AIF_RX;
			st_r.c1_half   <= 6'h02;
			st_r.c2_half   <= 6'h04;
		end else begin
			st_r <= st_nxt;
		end
	end

	// =====================================================
	// outputs
	assign s_axi_awready       = !st_r.aw_got;
	assign s_axi_wready        = !st_r.w_got;
	assign s_axi_bvalid        = st_r.bvalid;
	assign s_axi_bresp         = st_r.bresp;
	assign s_axi_arready       = !st_r.rvalid;
	assign s_axi_rvalid        = st_r.rvalid;
	assign s_axi_rresp         = st_r.rresp;
	assign s_axi_rdata         = st_r.rdata;
	assign clock_out_branch    = st_r.c1_lvl;
	assign master_clock_branch = st_r.c2_lvl;
	assign mclk_pin_oe         = st_r.aif_rx[POS_MS];
	assign mclk_pin_out        = st_r.mclk_out;
	assign tx_ref_clk          = st_r.tx_ref;
	assign pll_osc_en          = st_r.halve ? (osc_clk_en && st_r.halve_tog) : osc_clk_en;
	assign pll_ratio           = st_r.post_div[POS_FRACTIONAL_ENABLE] ?
		{st_r.int_part, st_r.frac} : {st_r.int_part, 22'h000000};
endmodule // pdmcc_top
